// ==== verilog/rtcc_map.vh ====
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH
// register offsets
`define RTCC_OFS_CTRL 8'h00
`define RTCC_OFS_STAT 8'h01
`define RTCC_OFS_DAY 8'h06
`define RTCC_OFS_MONTH 8'h07
`define RTCC_OFS_YEAR 8'h08
`define RTCC_OFS_SEC_AL 8'h09
`define RTCC_OFS_MIN_AL 8'h0A
`define RTCC_OFS_HOUR_AL 8'h0B
`define RTCC_OFS_WEEK_AL 8'h0C
`define RTCC_OFS_DAY_AL 8'h0D
`define RTCC_OFS_MONTH_AL 8'h0E
`define RTCC_OFS_SUMMARY 8'h90
// control register fields
`define RTCC_CTRL_STOP 0
`define RTCC_CTRL_IRQ_EN 1
`define RTCC_CTRL_UPDATE 5
// status register fields
`define RTCC_STAT_ALARM 1
`define RTCC_STAT_ONE_SEC 2
`define RTCC_STAT_HALF_SEC 3
// summary register field
`define RTCC_SUM_CLOCK 0
// alarm match enable bit
`define RTCC_MATCH_EN 7
// writable bit masks
`define RTCC_MASK_DAY 8'h3F
`define RTCC_MASK_MONTH 8'h1F
`define RTCC_MASK_HOUR_AL 8'hBF
`define RTCC_MASK_WEEK_AL 8'h87
`define RTCC_MASK_DAY_AL 8'hBF
`define RTCC_MASK_MONTH_AL 8'h9F
// reset values
`define RTCC_RST_ALARM 8'h00
`define RTCC_RST_CTRL 8'h00
// calendar constants
`define RTCC_DAY_FIRST 8'h01
`define RTCC_MONTH_FIRST 8'h01
`define RTCC_MONTH_LAST 8'h12
`define RTCC_LEN_LONG 8'h31
`define RTCC_LEN_SHORT 8'h30
`define RTCC_LEN_FEB 8'h28
`define RTCC_LEN_FEB_LEAP 8'h29
`endif

// ==== verilog/rtcc_date_step.v ====
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_date_step (
  input wire [7:0] day,
  input wire [7:0] month,
  input wire [7:0] year,
  output reg [7:0] next_day,
  output reg [7:0] next_month,
  output reg [7:0] next_year
);
  // two-digit bcd increment, 99 wraps to 00
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = (v[7:4] == 4'h9) ? 8'h00 : {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // year multiple of four: even tens with 0/4/8, odd tens with 2/6
  function leap;
    input [7:0] y;
    begin
      if (y[4]) begin
        leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
        leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
    end
  endfunction

  reg [7:0] month_len;

  always @* begin
    case (month)
      8'h04, 8'h06, 8'h09, 8'h11: month_len = `RTCC_LEN_SHORT;
      8'h02: month_len = leap(year) ? `RTCC_LEN_FEB_LEAP : `RTCC_LEN_FEB;
      default: month_len = `RTCC_LEN_LONG;
    endcase
    next_day = bcd_inc(day);
    next_month = month;
    next_year = year;
    if (day == month_len) begin
      next_day = `RTCC_DAY_FIRST;
      if (month == `RTCC_MONTH_LAST) begin
        next_month = `RTCC_MONTH_FIRST;
        next_year = bcd_inc(year);
      end else begin
        next_month = bcd_inc(month);
      end
    end
  end
endmodule // rtcc_date_step

// ==== verilog/rtcc_alarm_match.v ====
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_alarm_match (
  input wire [7:0] sec_count,
  input wire [7:0] min_count,
  input wire [7:0] hour_count,
  input wire [7:0] week_count,
  input wire [7:0] day_count,
  input wire [7:0] month_count,
  input wire [7:0] second_alarm,
  input wire [7:0] minute_alarm,
  input wire [7:0] hour_alarm,
  input wire [7:0] weekday_alarm,
  input wire [7:0] day_alarm,
  input wire [7:0] month_alarm,
  output wire match
);
  // one field passes when disabled or equal in its value bits
  function field_ok;
    input [7:0] al;
    input [7:0] cnt;
    begin
      field_ok = !al[`RTCC_MATCH_EN] || (al[6:0] == cnt[6:0]);
    end
  endfunction

  wire any_en;
  wire all_ok;

  assign any_en = second_alarm[7] | minute_alarm[7] | hour_alarm[7] |
    weekday_alarm[7] | day_alarm[7] | month_alarm[7];
  assign all_ok = field_ok(second_alarm, sec_count) &
    field_ok(minute_alarm, min_count) &
    field_ok(hour_alarm, hour_count) &
    field_ok(weekday_alarm, {5'h00, week_count[2:0]}) &
    field_ok(day_alarm, day_count) &
    field_ok(month_alarm, month_count);
  assign match = any_en & all_ok;
endmodule // rtcc_alarm_match

// ==== verilog/rtcc_calendar.v ====
// Overview of operation
// - day counts 1 to month length, bcd
// - month counts 1..12, wrap carries into year
// - year is two-digit bcd, 0 to 99
// - year divisible by four gives leap February
// - bit 7 enables each alarm field compare
// - six alarms compare against matching time and date counters
// - weekday code 0 Sunday through 6 Saturday
// - summary flag follows any clock event flag
// - writing zero clears the summary flag only while no event flag is set
// - date counters unreset, alarms reset to zero
// - alarm flag set on match, cleared by zero
// - alarm interrupt only when its enable set
// - hour wrap advances day, month and year while running
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_calendar (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [7:0] sec_count,
  input wire [7:0] min_count,
  input wire [7:0] hour_count,
  input wire [7:0] week_count,
  input wire hour_wrap,
  input wire sec_tick,
  input wire half_tick,
  output reg alarm_irq,
  output reg clock_summary_flag,
  output reg counting_stopped
);
  // date counters, no reset value
  reg [7:0] day_counter;
  reg [7:0] month_counter;
  reg [7:0] year_counter;
  // staged values written by software
  reg [7:0] day_stage;
  reg [7:0] month_stage;
  reg [7:0] year_stage;
  // alarm registers
  reg [7:0] second_alarm;
  reg [7:0] minute_alarm;
  reg [7:0] hour_alarm;
  reg [7:0] weekday_alarm;
  reg [7:0] day_alarm;
  reg [7:0] month_alarm;
  // control and status
  reg alarm_irq_enable;
  reg counter_update_request;
  reg alarm_flag;
  reg one_second_flag;
  reg half_second_flag;
  reg compare_due;
  reg [7:0] next_rdata;
  // control reset value split into its bits
  localparam [7:0] ctrl_rst = `RTCC_RST_CTRL;

  wire [7:0] next_day;
  wire [7:0] next_month;
  wire [7:0] next_year;
  wire alarm_match;

  // write decodes
  wire wr_ctrl;
  wire wr_stat;
  wire wr_day;
  wire wr_month;
  wire wr_year;
  wire wr_sec_al;
  wire wr_min_al;
  wire wr_hour_al;
  wire wr_week_al;
  wire wr_day_al;
  wire wr_month_al;
  wire wr_summary;

  // event and clear terms
  wire date_advance;
  wire load_counters;
  wire clr_alarm;
  wire clr_one_sec;
  wire clr_half_sec;
  wire clr_summary;
  wire set_alarm;
  wire any_event;
  wire update_wr;
  wire counter_moved;
  wire [7:0] ctrl_view;
  wire [7:0] stat_view;

  // one strobe at one register offset
  function reg_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = strobe && (addr == ofs);
    end
  endfunction

  // writing zero to a set flag clears it
  function zero_clear;
    input wr;
    input wbit;
    input flag;
    begin
      zero_clear = wr && !wbit && flag;
    end
  endfunction

  assign wr_ctrl = reg_hit(reg_wr, reg_addr, `RTCC_OFS_CTRL);
  assign wr_stat = reg_hit(reg_wr, reg_addr, `RTCC_OFS_STAT);
  assign wr_day = reg_hit(reg_wr, reg_addr, `RTCC_OFS_DAY);
  assign wr_month = reg_hit(reg_wr, reg_addr, `RTCC_OFS_MONTH);
  assign wr_year = reg_hit(reg_wr, reg_addr, `RTCC_OFS_YEAR);
  assign wr_sec_al = reg_hit(reg_wr, reg_addr, `RTCC_OFS_SEC_AL);
  assign wr_min_al = reg_hit(reg_wr, reg_addr, `RTCC_OFS_MIN_AL);
  assign wr_hour_al = reg_hit(reg_wr, reg_addr, `RTCC_OFS_HOUR_AL);
  assign wr_week_al = reg_hit(reg_wr, reg_addr, `RTCC_OFS_WEEK_AL);
  assign wr_day_al = reg_hit(reg_wr, reg_addr, `RTCC_OFS_DAY_AL);
  assign wr_month_al = reg_hit(reg_wr, reg_addr, `RTCC_OFS_MONTH_AL);
  assign wr_summary = reg_hit(reg_wr, reg_addr, `RTCC_OFS_SUMMARY);

  // date advances only on an hour wrap while running
  assign date_advance = hour_wrap && !counting_stopped;
  assign load_counters = counter_update_request;

  // update request strobe from a control write
  assign update_wr = wr_ctrl && reg_wdata[`RTCC_CTRL_UPDATE];

  // any change of the time or date counters
  assign counter_moved = sec_tick || date_advance || load_counters;

  // write zero while the flag is one clears it
  assign clr_alarm = zero_clear(wr_stat, reg_wdata[`RTCC_STAT_ALARM], alarm_flag);
  assign clr_one_sec = zero_clear(wr_stat, reg_wdata[`RTCC_STAT_ONE_SEC], one_second_flag);
  assign clr_half_sec = zero_clear(wr_stat, reg_wdata[`RTCC_STAT_HALF_SEC], half_second_flag);
  assign clr_summary = zero_clear(wr_summary, reg_wdata[`RTCC_SUM_CLOCK],
    clock_summary_flag);

  // compare only in the cycle after a counter update
  assign set_alarm = compare_due && alarm_match;
  assign any_event = alarm_flag || one_second_flag || half_second_flag;

  rtcc_date_step u_step (
    .day(day_counter),
    .month(month_counter),
    .year(year_counter),
    .next_day(next_day),
    .next_month(next_month),
    .next_year(next_year)
  );

  rtcc_alarm_match u_match (
    .sec_count(sec_count),
    .min_count(min_count),
    .hour_count(hour_count),
    .week_count(week_count),
    .day_count(day_counter),
    .month_count(month_counter),
    .second_alarm(second_alarm),
    .minute_alarm(minute_alarm),
    .hour_alarm(hour_alarm),
    .weekday_alarm(weekday_alarm),
    .day_alarm(day_alarm),
    .month_alarm(month_alarm),
    .match(alarm_match)
  );

  // date counters, left without reset on purpose
  always @(posedge ref_clk) begin
    if (load_counters) begin
      day_counter <= day_stage;
      month_counter <= month_stage;
      year_counter <= year_stage;
    end else if (date_advance) begin
      day_counter <= next_day;
      month_counter <= next_month;
      year_counter <= next_year;
    end
  end

  // staging registers keep software values until the update
  always @(posedge ref_clk) begin
    if (wr_day) begin
      day_stage <= reg_wdata & `RTCC_MASK_DAY;
    end
    if (wr_month) begin
      month_stage <= reg_wdata & `RTCC_MASK_MONTH;
    end
    if (wr_year) begin
      year_stage <= reg_wdata;
    end
  end

  // alarm registers, read-only bits held at zero
  always @(posedge ref_clk) begin
    if (!nrst) begin
      second_alarm <= `RTCC_RST_ALARM;
      minute_alarm <= `RTCC_RST_ALARM;
      hour_alarm <= `RTCC_RST_ALARM;
      weekday_alarm <= `RTCC_RST_ALARM;
      day_alarm <= `RTCC_RST_ALARM;
      month_alarm <= `RTCC_RST_ALARM;
    end else begin
      if (wr_sec_al) begin
        second_alarm <= reg_wdata;
      end
      if (wr_min_al) begin
        minute_alarm <= reg_wdata;
      end
      if (wr_hour_al) begin
        hour_alarm <= reg_wdata & `RTCC_MASK_HOUR_AL;
      end
      if (wr_week_al) begin
        weekday_alarm <= reg_wdata & `RTCC_MASK_WEEK_AL;
      end
      if (wr_day_al) begin
        day_alarm <= reg_wdata & `RTCC_MASK_DAY_AL;
      end
      if (wr_month_al) begin
        month_alarm <= reg_wdata & `RTCC_MASK_MONTH_AL;
      end
    end
  end

  // control register
  always @(posedge ref_clk) begin
    if (!nrst) begin
      counting_stopped <= ctrl_rst[`RTCC_CTRL_STOP];
      alarm_irq_enable <= ctrl_rst[`RTCC_CTRL_IRQ_EN];
      counter_update_request <= ctrl_rst[`RTCC_CTRL_UPDATE];
    end else begin
      if (wr_ctrl) begin
        counting_stopped <= reg_wdata[`RTCC_CTRL_STOP];
        alarm_irq_enable <= reg_wdata[`RTCC_CTRL_IRQ_EN];
      end
      if (update_wr) begin
        counter_update_request <= 1'b1;
      end else if (load_counters) begin
        counter_update_request <= 1'b0;
      end
    end
  end

  // compare strobe after any counter change
  always @(posedge ref_clk) begin
    if (!nrst) begin
      compare_due <= 1'b0;
    end else begin
      compare_due <= counter_moved;
    end
  end

  // event flags, a set in the clearing cycle wins
  always @(posedge ref_clk) begin
    if (!nrst) begin
      alarm_flag <= 1'b0;
      one_second_flag <= 1'b0;
      half_second_flag <= 1'b0;
    end else begin
      if (set_alarm) begin
        alarm_flag <= 1'b1;
      end else if (clr_alarm) begin
        alarm_flag <= 1'b0;
      end
      if (sec_tick) begin
        one_second_flag <= 1'b1;
      end else if (clr_one_sec) begin
        one_second_flag <= 1'b0;
      end
      if (half_tick) begin
        half_second_flag <= 1'b1;
      end else if (clr_half_sec) begin
        half_second_flag <= 1'b0;
      end
    end
  end

  // summary flag and alarm interrupt
  always @(posedge ref_clk) begin
    if (!nrst) begin
      clock_summary_flag <= 1'b0;
      alarm_irq <= 1'b0;
    end else begin
      if (any_event) begin
        clock_summary_flag <= 1'b1;
      end else if (clr_summary) begin
        clock_summary_flag <= 1'b0;
      end
      alarm_irq <= alarm_flag && alarm_irq_enable;
    end
  end

  // register views for the read mux
  assign ctrl_view = {2'b00, counter_update_request, 3'b000, alarm_irq_enable,
    counting_stopped};
  assign stat_view = {4'h0, half_second_flag, one_second_flag, alarm_flag, 1'b0};

  // read mux, zero unless a read strobe selects a register
  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RTCC_OFS_CTRL: next_rdata = ctrl_view;
        `RTCC_OFS_STAT: next_rdata = stat_view;
        `RTCC_OFS_DAY: next_rdata = day_counter & `RTCC_MASK_DAY;
        `RTCC_OFS_MONTH: next_rdata = month_counter & `RTCC_MASK_MONTH;
        `RTCC_OFS_YEAR: next_rdata = year_counter;
        `RTCC_OFS_SEC_AL: next_rdata = second_alarm;
        `RTCC_OFS_MIN_AL: next_rdata = minute_alarm;
        `RTCC_OFS_HOUR_AL: next_rdata = hour_alarm;
        `RTCC_OFS_WEEK_AL: next_rdata = weekday_alarm;
        `RTCC_OFS_DAY_AL: next_rdata = day_alarm;
        `RTCC_OFS_MONTH_AL: next_rdata = month_alarm;
        `RTCC_OFS_SUMMARY: next_rdata = {7'h00, clock_summary_flag};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // rtcc_calendar

// ==== testbench/rtcc_calendar_chk.sv ====
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_calendar_chk (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire sec_tick,
  input wire half_tick,
  input wire alarm_irq,
  input wire clock_summary_flag,
  input wire counting_stopped
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  property p_reset;
    $rose(nrst) |-> reg_rdata == 8'h00 && !alarm_irq
      && !clock_summary_flag && !counting_stopped;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_tick_sum;
    sec_tick || half_tick |-> ##2 clock_summary_flag;
  endproperty
  a_tick_sum: assert property (p_tick_sum) else $error("summary not set by tick");
  property p_sum_clear;
    $fell(clock_summary_flag) && $past(nrst) |->
      $past(reg_wr && reg_addr == `RTCC_OFS_SUMMARY && !reg_wdata[0]);
  endproperty
  a_sum_clear: assert property (p_sum_clear) else $error("summary fell without clear");
  property p_irq_sum;
    $rose(alarm_irq) |-> clock_summary_flag;
  endproperty
  a_irq_sum: assert property (p_irq_sum) else $error("irq without summary");
  property p_irq_off;
    reg_wr && reg_addr == `RTCC_OFS_CTRL && !reg_wdata[`RTCC_CTRL_IRQ_EN] |=> ##1 !alarm_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_stop;
    reg_wr && reg_addr == `RTCC_OFS_CTRL |=>
      counting_stopped == $past(reg_wdata[`RTCC_CTRL_STOP]);
  endproperty
  a_stop: assert property (p_stop) else $error("stop bit not taken");
  property p_week_ro;
    reg_rd && reg_addr == `RTCC_OFS_WEEK_AL |=> reg_rdata[6:3] == 4'h0;
  endproperty
  a_week_ro: assert property (p_week_ro) else $error("weekday alarm upper bits set");
  property p_year;
    reg_rd && reg_addr == `RTCC_OFS_YEAR |=> reg_rdata[7:4] < 4'hA && reg_rdata[3:0] < 4'hA;
  endproperty
  a_year: assert property (p_year) else $error("year not bcd");
endmodule // rtcc_calendar_chk
bind rtcc_calendar rtcc_calendar_chk u_rtcc_calendar_chk (.ref_clk(ref_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sec_tick(sec_tick), .half_tick(half_tick), .alarm_irq(alarm_irq),
  .clock_summary_flag(clock_summary_flag), .counting_stopped(counting_stopped));

// ==== testbench/test_rtcc_calendar.sv ====
`timescale 1ns/1ps
`include "rtcc_map.vh"
module test_rtcc_calendar;
  reg ref_clk = 1'h0;
  reg nrst = 1'h0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  reg [7:0] sec_count = 8'h30;
  reg [7:0] min_count = 8'h45;
  reg [7:0] hour_count = 8'h12;
  reg [7:0] week_count = 8'h00;
  reg hour_wrap = 1'h0;
  reg sec_tick = 1'h0;
  reg half_tick = 1'h0;
  wire [7:0] reg_rdata;
  wire alarm_irq;
  wire clock_summary_flag;
  wire counting_stopped;
  integer errors = 0;
  integer n_compared = 0;
  integer i;
  reg [47:0] tmp;
  reg [47:0] rows [0:19];
  rtcc_calendar u_rtcc_calendar (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sec_count(sec_count), .min_count(min_count), .hour_count(hour_count),
    .week_count(week_count), .hour_wrap(hour_wrap), .sec_tick(sec_tick),
    .half_tick(half_tick), .alarm_irq(alarm_irq), .clock_summary_flag(clock_summary_flag),
    .counting_stopped(counting_stopped));
  always #2 ref_clk = ~ref_clk;
  task give_verdict;
    begin
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
      @(posedge ref_clk);
    end
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    begin
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 chk8(reg_rdata, exp);
      @(posedge ref_clk);
    end
  endtask
  // pulses hour_wrap, sec_tick, half_tick as selected
  task tick(input [2:0] w);
    begin
      {hour_wrap, sec_tick, half_tick} <= w;
      @(posedge ref_clk);
      {hour_wrap, sec_tick, half_tick} <= 3'h0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
  task load(input [7:0] d, input [7:0] m, input [7:0] y);
    begin
      wr(`RTCC_OFS_CTRL, 8'h01);
      wr(`RTCC_OFS_DAY, d);
      wr(`RTCC_OFS_MONTH, m);
      wr(`RTCC_OFS_YEAR, y);
      wr(`RTCC_OFS_CTRL, 8'h21);
      wr(`RTCC_OFS_CTRL, 8'h00);
    end
  endtask
  initial begin
    #100000;
    errors = errors + 1;
    $display("CHECK FAILED at %0t: run too long", $time);
    give_verdict;
  end
  initial begin
    // day month year, then the date after one hour wrap
    rows[0] = 48'h310123_010223;
    rows[1] = 48'h300123_310123;
    rows[2] = 48'h300423_010523;
    rows[3] = 48'h280223_010323;
    rows[4] = 48'h280224_290224;
    rows[5] = 48'h290200_010300;
    rows[6] = 48'h280296_290296;
    rows[7] = 48'h311299_010100;
    rows[8] = 48'h311223_010124;
    rows[9] = 48'h090605_100605;
    rows[10] = 48'h300923_011023;
    rows[11] = 48'h310523_010623;
    rows[12] = 48'h300623_010723;
    rows[13] = 48'h311023_011123;
    rows[14] = 48'h301123_011223;
    rows[15] = 48'h310823_010923;
    rows[16] = 48'h310323_010423;
    rows[17] = 48'h310723_010823;
    rows[18] = 48'h280212_290212;
    rows[19] = 48'h280210_010310;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'h1;
    for (i = 0; i < 20; i = i + 1) begin
      load(rows[i][47:40], rows[i][39:32], rows[i][31:24]);
      tick(3'h4);
      rdc(`RTCC_OFS_DAY, rows[i][23:16]);
      rdc(`RTCC_OFS_MONTH, rows[i][15:8]);
      rdc(`RTCC_OFS_YEAR, rows[i][7:0]);
    end
    wr(`RTCC_OFS_CTRL, 8'h01);
    tick(3'h4);
    rdc(`RTCC_OFS_DAY, 8'h01);
    chk8({7'h00, counting_stopped}, 8'h01);
    $display("test date rows done");
    for (i = 9; i < 15; i = i + 1)
      rdc(i[7:0], 8'h00);
    rdc(`RTCC_OFS_SUMMARY, 8'h00);
    for (i = 9; i < 15; i = i + 1) begin
      tmp = 48'hFFFFBF87BF9F >> (8 * (14 - i));
      wr(i[7:0], 8'hFF);
      rdc(i[7:0], tmp[7:0]);
    end
    wr(8'h50, 8'hFF);
    rdc(8'h50, 8'h00);
    $display("test register map done");
    load(8'h15, 8'h08, 8'h23);
    wr(`RTCC_OFS_SEC_AL, 8'h16);
    wr(`RTCC_OFS_MIN_AL, 8'hC5);
    wr(`RTCC_OFS_HOUR_AL, 8'h92);
    wr(`RTCC_OFS_DAY_AL, 8'h95);
    wr(`RTCC_OFS_MONTH_AL, 8'h88);
    wr(`RTCC_OFS_CTRL, 8'h02);
    for (i = 0; i < 7; i = i + 1) begin
      week_count <= i[7:0];
      wr(`RTCC_OFS_WEEK_AL, 8'h80 | i[7:0]);
      tick(3'h2);
      chk8({7'h00, alarm_irq}, 8'h01);
      rdc(`RTCC_OFS_STAT, 8'h06);
      wr(`RTCC_OFS_STAT, 8'h00);
      rdc(`RTCC_OFS_STAT, 8'h00);
      chk8({7'h00, alarm_irq}, 8'h00);
    end
    hour_count <= 8'h13;
    tick(3'h2);
    rdc(`RTCC_OFS_STAT, 8'h04);
    hour_count <= 8'h12;
    wr(`RTCC_OFS_SEC_AL, 8'hB0);
    wr(`RTCC_OFS_CTRL, 8'h00);
    wr(`RTCC_OFS_STAT, 8'h00);
    tick(3'h2);
    rdc(`RTCC_OFS_STAT, 8'h06);
    chk8({7'h00, alarm_irq}, 8'h00);
    $display("test alarm done");
    rdc(`RTCC_OFS_SUMMARY, 8'h01);
    wr(`RTCC_OFS_SUMMARY, 8'h00);
    rdc(`RTCC_OFS_SUMMARY, 8'h01);
    chk8({7'h00, clock_summary_flag}, 8'h01);
    wr(`RTCC_OFS_STAT, 8'h00);
    wr(`RTCC_OFS_SUMMARY, 8'h00);
    rdc(`RTCC_OFS_SUMMARY, 8'h00);
    chk8({7'h00, clock_summary_flag}, 8'h00);
    tick(3'h1);
    rdc(`RTCC_OFS_SUMMARY, 8'h01);
    rdc(`RTCC_OFS_STAT, 8'h08);
    $display("test summary done");
    nrst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    rdc(`RTCC_OFS_DAY_AL, 8'h00);
    rdc(`RTCC_OFS_SUMMARY, 8'h00);
    chk8({7'h00, clock_summary_flag}, 8'h00);
    chk8({7'h00, counting_stopped}, 8'h00);
    $display("test second reset done");
    give_verdict;
  end
endmodule // test_rtcc_calendar
